/* File: rtl/eas_bus_ctrl.sv */
// module: strap-steered memory routing and external bus cycle strobes
// Notes on behaviour
// [R1] strap level is captured only when reset is released, then held
// [R2] strap changes after release leave routing and mode untouched
// [R3] captured high: partition accesses go to on-chip memory
// [R4] captured low: partition accesses run an external bus cycle
// [R5] other locations route identically whatever the captured strap
// [R6] strap at programming voltage on release enters programming mode
// [R7] latch strobe high only during external cycles, never on-chip
// [R8] strobe opens each external cycle while address is on bus, when adv_mode is low
// [R9] outside latch captures address under strobe for data phase
// [R10] address phase drives address lines, data phase moves 8 or 16 bits
// [R11] address-valid mode: low for whole cycle, high once it ends
// [R12] on-chip partition accesses make no bus cycle and no strobe
module eas_bus_ctrl (
   // clock and control
   input  wire logic                       sys_clk,
   input  wire logic                       reset,
   input  wire logic                       clk_en,
   // strap pins
   input  wire logic                       ext_access_strap_n,
   input  wire logic                       programming_voltage,
   // pin configuration: 1 selects active-low address valid
   input  wire logic                       adv_mode,
   // cpu request
   input  wire logic                       cpu_req,
   input  wire logic                       cpu_write,
   input  wire logic                       cpu_wide,
   input  wire logic [eas_pkg::ADDR_W-1:0] cpu_addr,
   input  wire logic [eas_pkg::DATA_W-1:0] cpu_wdata,
   // cpu answer
   output logic                            cpu_busy,
   output logic                            cpu_ack,
   output logic                            cpu_onchip,
   output logic [eas_pkg::DATA_W-1:0]      cpu_rdata,
   // mode
   output logic                            prog_mode,
   // external bus
   input  wire logic [eas_pkg::DATA_W-1:0] muxed_addr_data_bus_in,
   output logic [eas_pkg::DATA_W-1:0]      muxed_addr_data_bus_out,
   output logic [eas_pkg::DATA_W-1:0]      muxed_addr_data_bus_oe,
   output logic                            ale,
   output logic                            addr_valid_n,
   output logic                            bus_read_n,
   output logic                            bus_write_n
);
   // strap value captured at release, held until reset is asserted again
   logic                    strap_q;
   eas_pkg::eas_bus_state_e state;
   eas_pkg::eas_bus_state_e next_state;
   logic [1:0]              cnt;
   logic [1:0]              next_cnt;
   logic                    wr;
   logic                    next_wr;
   logic                    wide;
   logic                    next_wide;
   logic [15:0]             wdata;
   logic [15:0]             next_wdata;
   logic                    in_sp;
   logic                    in_prog;
   logic                    in_ext_win;
   logic                    is_part;
   logic                    go_ext;
   logic                    next_busy;
   logic                    next_ack;
   logic                    next_onchip;
   logic [15:0]             next_rdata;
   logic [15:0]             next_out;
   logic [15:0]             next_oe;
   logic                    next_ale;
   logic                    next_advn;
   logic                    next_rdn;
   logic                    next_wrn;

   eas_strap_latch u_strap (
      .sys_clk      (sys_clk),
      .reset        (reset),
      .clk_en       (clk_en),
      .strap_level  (ext_access_strap_n),
      .strap_at_vpp (programming_voltage),
      .strap_q      (strap_q),
      .prog_mode    (prog_mode)
   );

   // partition decode; everything else keeps a fixed route
   always_comb begin
      in_sp      = (cpu_addr >= eas_pkg::SP_PART_LO) && (cpu_addr <= eas_pkg::SP_PART_HI);
      in_prog    = (cpu_addr >= eas_pkg::PROG_PART_LO) && (cpu_addr <= eas_pkg::PROG_PART_HI);
      // fixed external window between the on-chip registers and the partitions
      in_ext_win = (cpu_addr > eas_pkg::ONCHIP_REG_HI) && (cpu_addr < eas_pkg::SP_PART_LO);
      is_part    = in_sp || in_prog;
      if (is_part) begin
         go_ext = !strap_q;                               // [R3] [R4]
      end else begin
         go_ext = in_ext_win;                             // [R5]
      end
   end

   // one request at a time: address phase, data phase, then a turnaround
   always_comb begin
      next_state  = state;
      next_cnt    = cnt;
      next_wr     = wr;
      next_wide   = wide;
      next_wdata  = wdata;
      next_busy   = 1'b1;
      next_ack    = 1'b0;
      next_onchip = 1'b0;
      next_rdata  = cpu_rdata;
      next_out    = muxed_addr_data_bus_out;
      next_oe     = 16'h0000;
      next_ale    = 1'b0;
      next_advn   = 1'b1;
      next_rdn    = 1'b1;
      next_wrn    = 1'b1;
      unique case (state)
         eas_pkg::EAS_IDLE: begin
            next_busy = 1'b0;
            // programming mode shuts out normal cpu traffic
            if (cpu_req && !prog_mode) begin
               if (go_ext) begin
                  next_state = eas_pkg::EAS_ADDR;
                  next_cnt   = 2'(eas_pkg::ADDR_PHASE_CYC - 1);
                  next_wr    = cpu_write;
                  next_wide  = cpu_wide;
                  next_wdata = cpu_wdata;
                  next_out   = cpu_addr;                 // [R10]
                  next_oe    = 16'hFFFF;
                  next_ale   = !adv_mode;                // [R8]
                  next_advn  = !adv_mode;                // [R11]
                  next_busy  = 1'b1;
               end else begin
                  // on-chip: answer at once, strobe and bus stay quiet
                  next_ack    = 1'b1;                    // [R12]
                  next_onchip = 1'b1;
               end
            end
         end
         eas_pkg::EAS_ADDR: begin
            // address and strobe held for the whole address phase
            next_out  = muxed_addr_data_bus_out;
            next_oe   = 16'hFFFF;
            next_ale  = ale;                             // [R7]
            next_advn = addr_valid_n;
            if (cnt != eas_pkg::PHASE_CNT_RST) begin
               next_cnt = cnt - 2'h1;
            end else begin
               next_state = eas_pkg::EAS_DATA;
               next_cnt   = 2'(eas_pkg::DATA_PHASE_CYC - 1);
               next_ale   = 1'b0;
               // narrow write drives only the low byte lanes
               next_out   = wide ? wdata : {8'h00, wdata[7:0]};
               next_oe    = wr ? (wide ? 16'hFFFF : 16'h00FF) : 16'h0000;
               next_rdn   = wr;
               next_wrn   = !wr;
            end
         end
         eas_pkg::EAS_DATA: begin
            next_advn = addr_valid_n;
            next_oe   = muxed_addr_data_bus_oe;
            next_rdn  = bus_read_n;
            next_wrn  = bus_write_n;
            if (cnt != eas_pkg::PHASE_CNT_RST) begin
               next_cnt = cnt - 2'h1;
            end else begin
               next_state = eas_pkg::EAS_DONE;
               // narrow read returns zero in the upper byte
               next_rdata = wide ? muxed_addr_data_bus_in
                                 : {8'h00, muxed_addr_data_bus_in[7:0]};
               next_ack   = 1'b1;
               next_advn  = 1'b1;                        // [R11]
               next_oe    = 16'h0000;
               next_rdn   = 1'b1;
               next_wrn   = 1'b1;
            end
         end
         eas_pkg::EAS_DONE: begin
            // one idle cycle so the bus turns round before the next address
            next_state = eas_pkg::EAS_IDLE;
            next_busy  = 1'b0;
         end
      endcase
   end

   // reset wins over clk_en so a stalled clock still parks the bus
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state                   <= eas_pkg::EAS_IDLE;
         cnt                     <= eas_pkg::PHASE_CNT_RST;
         wr                      <= 1'b0;
         wide                    <= 1'b0;
         wdata                   <= 16'h0000;
         cpu_busy                <= 1'b0;
         cpu_ack                 <= 1'b0;
         cpu_onchip              <= 1'b0;
         cpu_rdata               <= 16'h0000;
         muxed_addr_data_bus_out <= 16'h0000;
         muxed_addr_data_bus_oe  <= 16'h0000;
         ale                     <= 1'b0;
         addr_valid_n            <= 1'b1;
         bus_read_n              <= 1'b1;
         bus_write_n             <= 1'b1;
      end else if (clk_en) begin
         state                   <= next_state;
         cnt                     <= next_cnt;
         wr                      <= next_wr;
         wide                    <= next_wide;
         wdata                   <= next_wdata;
         cpu_busy                <= next_busy;
         cpu_ack                 <= next_ack;
         cpu_onchip              <= next_onchip;
         cpu_rdata               <= next_rdata;
         muxed_addr_data_bus_out <= next_out;
         muxed_addr_data_bus_oe  <= next_oe;
         ale                     <= next_ale;
         addr_valid_n            <= next_advn;
         bus_read_n              <= next_rdn;
         bus_write_n             <= next_wrn;
      end
   end
endmodule : eas_bus_ctrl

/* File: rtl/eas_pkg.sv */
// package: constants and types for the external-access strap and bus strobe block
package eas_pkg;
   localparam int         ADDR_W          = 16;
   localparam int         DATA_W          = 16;
   // partition windows: special-purpose and program memory
   localparam logic [15:0] SP_PART_LO     = 16'h1F00;
   localparam logic [15:0] SP_PART_HI     = 16'h1FFF;
   localparam logic [15:0] PROG_PART_LO   = 16'h2000;
   localparam logic [15:0] PROG_PART_HI   = 16'h7FFF;
   // locations up to and including this are on-chip registers whatever the strap says
   localparam logic [15:0] ONCHIP_REG_HI  = 16'h03FF;
   // bus timing in sys_clk cycles
   localparam int          ADDR_PHASE_CYC = 1;
   localparam int          DATA_PHASE_CYC = 2;
   localparam logic [1:0]  PHASE_CNT_RST  = 2'h0;
   localparam logic        STRAP_RST      = 1'b1;
   typedef enum logic [1:0] {
      EAS_IDLE,
      EAS_ADDR,
      EAS_DATA,
      EAS_DONE
   } eas_bus_state_e;
endpackage : eas_pkg

/* File: rtl/eas_strap_latch.sv */
// module: captures the strap levels on the release of reset
module eas_strap_latch (
   // clock and control
   input  wire logic sys_clk,
   input  wire logic reset,
   input  wire logic clk_en,
   // strap inputs
   input  wire logic strap_level,
   input  wire logic strap_at_vpp,
   // captured values
   output logic      strap_q,
   output logic      prog_mode
);
   logic reset_d;
   logic next_reset_d;
   logic next_strap_q;
   logic next_prog_mode;

   // sample exactly at the first enabled edge after reset falls
   always_comb begin
      next_reset_d   = reset;
      next_strap_q   = strap_q;
      next_prog_mode = prog_mode;
      if (reset_d && !reset) begin
         next_strap_q   = strap_level;   // [R1]
         next_prog_mode = strap_at_vpp;  // [R6]
      end
   end

   // values held until reset is asserted again, strap ignored otherwise
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         reset_d   <= 1'b1;
         strap_q   <= eas_pkg::STRAP_RST;
         prog_mode <= 1'b0;
      end else if (clk_en) begin
         reset_d   <= next_reset_d;
         strap_q   <= next_strap_q;     // [R2]
         prog_mode <= next_prog_mode;
      end
   end
endmodule : eas_strap_latch

/* File: dv/eas_ext_mem.sv */
// partner: external memory behind the address latch on the muxed bus
module eas_ext_mem (
   // bus from the device
   input  wire logic        sys_clk,
   input  wire logic        ale,
   input  wire logic        addr_valid_n,
   input  wire logic        bus_read_n,
   input  wire logic        bus_write_n,
   input  wire logic [15:0] bus_out,
   input  wire logic [15:0] bus_oe,
   // resolved wire and memory view
   output logic      [15:0] bus_in,
   output logic      [15:0] latched,
   output logic      [15:0] last_wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] drv;
   logic [15:0] pinv = 16'h0000;
   // released lines show the inverse of last level, not a stale copy
   assign drv = !bus_read_n ? ~latched : pinv;
   assign bus_in = (bus_out & bus_oe) | (drv & ~bus_oe);
   always @(posedge sys_clk) begin
      pinv <= ~bus_in;
      if ((ale || !addr_valid_n) && bus_oe === 16'hFFFF && bus_read_n && bus_write_n)
         latched <= bus_in;
      if (!bus_write_n)
         last_wdata <= bus_in;
   end
endmodule : eas_ext_mem

/* File: dv/eas_bus_ctrl_properties.sv */
// checker: timing relations on the strobe, bus and answer ports
module eas_bus_ctrl_properties (
   input wire logic        sys_clk,
   input wire logic        reset,
   input wire logic        cpu_ack,
   input wire logic        cpu_onchip,
   input wire logic        prog_mode,
   input wire logic [15:0] muxed_addr_data_bus_oe,
   input wire logic        ale,
   input wire logic        addr_valid_n,
   input wire logic        bus_read_n
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   a_ale_one_cycle: assert property (ale |=> !ale) else $error("ale too long");
   a_ale_drives_addr: assert property (ale |-> muxed_addr_data_bus_oe == 16'hFFFF)
      else $error("no address under ale");
   a_ack_after_ale: assert property (ale |-> ##3 cpu_ack) else $error("late ack");
   a_onchip_quiet: assert property (cpu_onchip |-> !ale && addr_valid_n)
      else $error("strobe on chip");
   a_valid_whole_cycle: assert property ($fell(addr_valid_n) |-> !addr_valid_n[*3] ##1
      addr_valid_n) else $error("valid width");
   a_read_data_phase: assert property ($fell(bus_read_n) |-> !bus_read_n[*2] ##1
      bus_read_n) else $error("read width");
   // settle two edges after release before the mode must freeze
   a_mode_held: assert property (!$past(reset) && !$past(reset, 2) |-> $stable(prog_mode))
      else $error("mode changed");
   a_prog_no_bus: assert property (prog_mode |-> !ale && !cpu_ack)
      else $error("bus in prog mode");
endmodule : eas_bus_ctrl_properties
bind eas_bus_ctrl eas_bus_ctrl_properties chk (.sys_clk(sys_clk), .reset(reset),
   .cpu_ack(cpu_ack), .cpu_onchip(cpu_onchip), .prog_mode(prog_mode),
   .muxed_addr_data_bus_oe(muxed_addr_data_bus_oe), .ale(ale),
   .addr_valid_n(addr_valid_n), .bus_read_n(bus_read_n));

/* File: dv/tb.sv */
// testbench: strap capture, routing and external cycles
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk = 0, reset = 1, sn = 1, vpp = 0, adv = 0;
   logic        req = 0, wr = 0, wide = 1;
   logic [15:0] addr = 16'h0000, wd = 16'h0000;
   logic        busy, ack, onc, pm, ale, avn, rdn, wrn;
   logic [15:0] rd, bo, boe, bi, la, lw;
   int          n_mismatch = 0, checks = 0, cyc = 0;
   always #20 sys_clk = ~sys_clk;
   eas_bus_ctrl uut (.sys_clk(sys_clk), .reset(reset), .clk_en(1'b1),
      .ext_access_strap_n(sn), .programming_voltage(vpp), .adv_mode(adv),
      .cpu_req(req), .cpu_write(wr), .cpu_wide(wide), .cpu_addr(addr), .cpu_wdata(wd),
      .cpu_busy(busy), .cpu_ack(ack), .cpu_onchip(onc), .cpu_rdata(rd), .prog_mode(pm),
      .muxed_addr_data_bus_in(bi), .muxed_addr_data_bus_out(bo),
      .muxed_addr_data_bus_oe(boe), .ale(ale), .addr_valid_n(avn),
      .bus_read_n(rdn), .bus_write_n(wrn));
   eas_ext_mem mem (.sys_clk(sys_clk), .ale(ale), .addr_valid_n(avn), .bus_read_n(rdn),
      .bus_write_n(wrn), .bus_out(bo), .bus_oe(boe), .bus_in(bi), .latched(la),
      .last_wdata(lw));
   task cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp
   task rst(input logic s, input logic v);
      @(negedge sys_clk);
      reset = 1;
      sn = s;
      vpp = v;
      repeat (4) @(negedge sys_clk);
      reset = 0;
      repeat (2) @(negedge sys_clk);
   endtask : rst
   // one request; ack is looked for in each cycle under a bound
   task acc(input logic [15:0] a, input logic w, wi, xa, xo);
      logic got;
      got = 0;
      addr = a;
      wr = w;
      wide = wi;
      wd = a ^ 16'h5A5A;
      req = 1;
      @(negedge sys_clk);
      req = 0;
      // busy only while an external cycle runs
      cmp("busy", {15'h0000, xa & ~xo}, {15'h0000, busy});
      for (int i = 0; i < 6 && !got; i++) begin
         if (ack === 1'b1) got = 1;
         else @(negedge sys_clk);
      end
      cmp("ack", {15'h0000, xa}, {15'h0000, got});
      if (got) cmp("onchip", {15'h0000, xo}, {15'h0000, onc});
      @(negedge sys_clk);
   endtask : acc
   task t_strap_high;
      rst(1, 0);
      acc(16'h1F00, 0, 1, 1, 1);
      acc(16'h2000, 1, 1, 1, 1);
      acc(16'h0400, 0, 1, 1, 0);
      cmp("latched", 16'h0400, la);
      acc(16'h0402, 0, 0, 1, 0);
      cmp("rdata", 16'h00FD, rd);
      sn = 0;
      acc(16'h7FFF, 0, 1, 1, 1);
      $display("test strap_high done");
   endtask : t_strap_high
   task t_strap_low;
      rst(0, 0);
      acc(16'h7FFF, 0, 1, 1, 0);
      cmp("rdata", ~16'h7FFF, rd);
      acc(16'h1F00, 1, 0, 1, 0);
      cmp("wdata", {8'h00, wd[7:0]}, {8'h00, lw[7:0]});
      acc(16'h0400, 1, 1, 1, 0);
      cmp("wdata", 16'h5E5A, lw);
      acc(16'h0000, 0, 1, 1, 1);
      adv = 1;
      acc(16'h2000, 0, 1, 1, 0);
      cmp("rdata", ~16'h2000, rd);
      adv = 0;
      sn = 1;
      acc(16'h1FFF, 0, 1, 1, 0);
      $display("test strap_low done");
   endtask : t_strap_low
   task t_prog;
      rst(1, 1);
      cmp("prog_mode", 16'h0001, {15'h0000, pm});
      acc(16'h0400, 0, 1, 0, 0);
      rst(1, 0);
      cmp("prog_mode", 16'h0000, {15'h0000, pm});
      $display("test prog done");
   endtask : t_prog
   task give_verdict;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : give_verdict
   // the tests take under a hundred cycles
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   initial begin
      t_strap_high();
      t_strap_low();
      t_prog();
      give_verdict();
   end
endmodule : tb
